/* verilog/spcr_regs.sv */
// Purpose: Protection threshold and fault response command register bank
// Assumes: Requests are one-cycle strobes from logic on the same clock
// Notes:   Rejected writes leave every register unchanged and raise O_ERR
`timescale 1ns/100ps

// Behaviour
// [RULE1] A register address is valid only when its eight bits hold odd parity.
// [RULE2] Parity word writes need odd parity in the high byte and the low byte.
// [RULE3] Overvoltage threshold takes codes 62 to 250 and resets to 62.
// [RULE4] Undervoltage threshold takes codes 30 to 240 and resets to 36.
// [RULE5] Cable drop compensation uses bits 3 to 0, codes 0 to 12, reset 0.
// [RULE6] Constant current limit takes codes 25 to 128 and resets to 128.
// [RULE7] Power knee voltage takes codes 53 to 240 and resets to 240.
// [RULE8] Overvoltage response: 00 none, 01 latch-off, 10 auto-restart, reset 10.
// [RULE9] Undervoltage response: 00 auto-restart, 01 latch-off, 10 none, reset 00.
// [RULE10] Sense short bits 3 to 2 pick the frequency and bits 1 to 0 the response.
// [RULE11] Undervoltage timer codes 00 to 11 give 8, 16, 32, 64 ms, reset 11.
// [RULE12] Watchdog codes give off, 0.5 s, 1 s, 2 s, reset 01; the host must talk in time.
// [RULE13] A threshold code is bit 8 above bits 6 to 0, parity positions ignored.
// [RULE14] A write failing address or data parity is rejected unchanged.
module spcr_regs #(
    parameter logic [31:0] WDG_BASE_CYCLES = spcr_pkg::WDG_BASE_CYC
) (
    input  wire logic                I_MCLK,
    input  wire logic                I_ARST_N,
    input  wire logic                I_CE,
    input  wire spcr_pkg::spcr_req_t I_REQ,
    output logic [15:0]              O_RDATA,
    output logic                     O_ACK,
    output logic                     O_ERR,
    output spcr_pkg::spcr_cfg_t      O_CFG,
    output logic                     O_WDOG_TRIP
);
    // ----------------------------------------------------------------
    // Address and data checks
    // ----------------------------------------------------------------
    wire logic [6:0] base    = I_REQ.addr[6:0];
    wire logic       addr_ok = ^I_REQ.addr;                          // [RULE1]
    wire logic       data_ok = (^I_REQ.wdata[15:8]) & (^I_REQ.wdata[7:0]); // [RULE2]
    wire logic [7:0] code    = {I_REQ.wdata[spcr_pkg::CODE_MSB],
                                I_REQ.wdata[6:0]};                   // [RULE13]
    wire logic [3:0] nib     = I_REQ.wdata[3:0];
    wire logic [1:0] two     = I_REQ.wdata[1:0];

    wire logic s_ov   = base == spcr_pkg::OFS_OV;
    wire logic s_uv   = base == spcr_pkg::OFS_UV;
    wire logic s_drop = base == spcr_pkg::OFS_DROP;
    wire logic s_ilim = base == spcr_pkg::OFS_ILIM;
    wire logic s_knee = base == spcr_pkg::OFS_KNEE;
    wire logic s_ovr  = base == spcr_pkg::OFS_OVR;
    wire logic s_uvr  = base == spcr_pkg::OFS_UVR;
    wire logic s_scr  = base == spcr_pkg::OFS_SCR;
    wire logic s_iss  = base == spcr_pkg::OFS_ISS;
    wire logic s_uvt  = base == spcr_pkg::OFS_UVT;
    wire logic s_wdg  = base == spcr_pkg::OFS_WDG;
    wire logic par_w  = s_ov | s_uv | s_ilim | s_knee;
    wire logic mapped = par_w | s_drop | s_ovr | s_uvr | s_scr | s_iss | s_uvt | s_wdg;

    // Value check per register; unknown response codes are refused
    wire logic val_ok =
        s_ov   ? (code >= spcr_pkg::MIN_OV   && code <= spcr_pkg::MAX_OV)   : // [RULE3]
        s_uv   ? (code >= spcr_pkg::MIN_UV   && code <= spcr_pkg::MAX_UV)   : // [RULE4]
        s_drop ? (nib <= spcr_pkg::MAX_DROP)                                : // [RULE5]
        s_ilim ? (code >= spcr_pkg::MIN_ILIM && code <= spcr_pkg::MAX_ILIM) : // [RULE6]
        s_knee ? (code >= spcr_pkg::MIN_KNEE && code <= spcr_pkg::MAX_KNEE) : // [RULE7]
        s_scr  ? (two == spcr_pkg::SC_NONE || two == spcr_pkg::SC_AR)       :
        (s_ovr | s_uvr | s_iss) ? (two != spcr_pkg::RESP_BAD) : 1'b1;     // [RULE8] [RULE9]

    wire logic acc    = I_CE & (I_REQ.wr | I_REQ.rd);
    wire logic wr_ok  = I_CE & I_REQ.wr & addr_ok & mapped
                        & (~par_w | data_ok) & val_ok;              // [RULE14]
    wire logic rd_ok  = I_CE & I_REQ.rd & ~I_REQ.wr & addr_ok & mapped;

    // ----------------------------------------------------------------
    // Read data with parity regenerated
    // ----------------------------------------------------------------
    function automatic logic [15:0] par_word(input logic [7:0] c);
        par_word = {~c[7], 6'h00, c[7], ~^c[6:0], c[6:0]};
    endfunction

    spcr_pkg::spcr_cfg_t cfg_reg;
    wire logic [15:0] rd_mux =
        s_ov   ? par_word(cfg_reg.ov)   :
        s_uv   ? par_word(cfg_reg.uv)   :
        s_ilim ? par_word(cfg_reg.ilim) :
        s_knee ? par_word(cfg_reg.knee) :
        s_drop ? {12'h000, cfg_reg.drop} :
        s_ovr  ? {14'h0000, cfg_reg.ovr} :
        s_uvr  ? {14'h0000, cfg_reg.uvr} :
        s_scr  ? {14'h0000, cfg_reg.scr} :
        s_iss  ? {12'h000, cfg_reg.iss} :
        s_uvt  ? {14'h0000, cfg_reg.uvt} : {14'h0000, cfg_reg.wdg};

    // ----------------------------------------------------------------
    // Register storage
    // ----------------------------------------------------------------
    always_ff @(posedge I_MCLK or negedge I_ARST_N) begin
        if (!I_ARST_N) begin
            cfg_reg <= '{spcr_pkg::RST_OV, spcr_pkg::RST_UV, spcr_pkg::RST_DROP,
                         spcr_pkg::RST_ILIM, spcr_pkg::RST_KNEE, spcr_pkg::RST_OVR,
                         spcr_pkg::RST_UVR, spcr_pkg::RST_SCR, spcr_pkg::RST_ISS,
                         spcr_pkg::RST_UVT, spcr_pkg::RST_WDG};
        end else if (wr_ok) begin
            if (s_ov)   cfg_reg.ov   <= code;                            // [RULE3]
            if (s_uv)   cfg_reg.uv   <= code;                            // [RULE4]
            if (s_drop) cfg_reg.drop <= nib;                             // [RULE5]
            if (s_ilim) cfg_reg.ilim <= code;                            // [RULE6]
            if (s_knee) cfg_reg.knee <= code;                            // [RULE7]
            if (s_ovr)  cfg_reg.ovr  <= two;                             // [RULE8]
            if (s_uvr)  cfg_reg.uvr  <= two;                             // [RULE9]
            if (s_scr)  cfg_reg.scr  <= two;
            if (s_iss)  cfg_reg.iss  <= nib;                             // [RULE10]
            if (s_uvt)  cfg_reg.uvt  <= two;                             // [RULE11]
            if (s_wdg)  cfg_reg.wdg  <= two;                             // [RULE12]
        end
    end

    always_ff @(posedge I_MCLK or negedge I_ARST_N) begin
        if (!I_ARST_N) begin
            O_RDATA <= 16'h0000;
            O_ACK   <= 1'b0;
            O_ERR   <= 1'b0;
        end else if (I_CE) begin
            O_RDATA <= rd_ok ? rd_mux : 16'h0000;
            O_ACK   <= acc;
            O_ERR   <= acc & ~(wr_ok | rd_ok);                           // [RULE14]
        end
    end

    assign O_CFG = cfg_reg;

    // ----------------------------------------------------------------
    // Communication watchdog
    // ----------------------------------------------------------------
    logic [31:0] wdg_cnt_reg;
    wire  logic [31:0] wdg_lim = (cfg_reg.wdg == spcr_pkg::WDG_1S) ? WDG_BASE_CYCLES << 1 :
                                 (cfg_reg.wdg == spcr_pkg::WDG_OFF) ? WDG_BASE_CYCLES :
                                 (cfg_reg.wdg[1] ? WDG_BASE_CYCLES << 2 : WDG_BASE_CYCLES);
    wire  logic wdg_hit = (cfg_reg.wdg != spcr_pkg::WDG_OFF)
                          && (wdg_cnt_reg == wdg_lim - 32'h1);      // [RULE12]

    always_ff @(posedge I_MCLK or negedge I_ARST_N) begin
        if (!I_ARST_N) begin
            wdg_cnt_reg <= 32'h0;
            O_WDOG_TRIP <= 1'b0;
        end else if (I_CE) begin
            wdg_cnt_reg <= (acc & addr_ok) | wdg_hit | (cfg_reg.wdg == spcr_pkg::WDG_OFF)
                           ? 32'h0 : wdg_cnt_reg + 32'h1;
            O_WDOG_TRIP <= wdg_hit & ~(acc & addr_ok);
        end
    end

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    default clocking @(posedge I_MCLK); endclocking
    default disable iff (!I_ARST_N);

    chk_addr_parity: assert property (I_CE && I_REQ.wr && !(^I_REQ.addr) // [RULE1]
        |=> $stable(O_CFG) && O_ERR) else $error("bad address parity write took effect");
    chk_data_parity: assert property (I_CE && I_REQ.wr && par_w &&       // [RULE2]
        !((^I_REQ.wdata[15:8]) && (^I_REQ.wdata[7:0])) |=> $stable(O_CFG) && O_ERR)
        else $error("bad data parity write took effect");
    chk_ov_range: assert property (O_CFG.ov >= 8'h3e && O_CFG.ov <= 8'hfa) // [RULE3]
        else $error("overvoltage code out of range");
    chk_uv_range: assert property (O_CFG.uv >= 8'h1e && O_CFG.uv <= 8'hf0) // [RULE4]
        else $error("undervoltage code out of range");
    chk_drop_range: assert property (O_CFG.drop <= 4'hc)                  // [RULE5]
        else $error("compensation code out of range");
    chk_ilim_range: assert property (O_CFG.ilim >= 8'h19 && O_CFG.ilim <= 8'h80) // [RULE6]
        else $error("current limit code out of range");
    chk_knee_range: assert property (O_CFG.knee >= 8'h35 && O_CFG.knee <= 8'hf0) // [RULE7]
        else $error("knee code out of range");
    chk_ovr_code: assert property (O_CFG.ovr != 2'h3)                     // [RULE8]
        else $error("overvoltage response reserved");
    chk_uvr_code: assert property (O_CFG.uvr != 2'h3)                     // [RULE9]
        else $error("undervoltage response reserved");
    chk_iss_write: assert property (wr_ok && s_iss                        // [RULE10]
        |=> O_CFG.iss == $past(I_REQ.wdata[3:0])) else $error("sense short write lost");
    chk_uvt_write: assert property (wr_ok && s_uvt                        // [RULE11]
        |=> O_CFG.uvt == $past(I_REQ.wdata[1:0])) else $error("timer write lost");
    chk_wdog_off: assert property (O_CFG.wdg == 2'h0 |=> !O_WDOG_TRIP)  // [RULE12]
        else $error("watchdog tripped while off");
    chk_code_assemble: assert property (wr_ok && s_ov                     // [RULE13]
        |=> O_CFG.ov == {$past(I_REQ.wdata[8]), $past(I_REQ.wdata[6:0])})
        else $error("threshold code assembled wrongly");
    chk_ack_err: assert property (I_CE && I_REQ.wr && !wr_ok |=> O_ACK && O_ERR) // [RULE14]
        else $error("rejected write not flagged");
endmodule

/* verilog/spcr_pkg.sv */
// Purpose: Shared constants and types of the supply protection command registers
// Assumes: 250 MHz core clock; requests come already decoded from the serial slave
// Notes:   Threshold codes are stored as 8-bit values without parity positions
package spcr_pkg;
    // ----------------------------------------------------------------
    // Register base addresses (seven bits, parity bit excluded)
    // ----------------------------------------------------------------
    localparam logic [6:0] OFS_OV   = 7'h12;
    localparam logic [6:0] OFS_UV   = 7'h14;
    localparam logic [6:0] OFS_DROP = 7'h16;
    localparam logic [6:0] OFS_ILIM = 7'h18;
    localparam logic [6:0] OFS_KNEE = 7'h1a;
    localparam logic [6:0] OFS_OVR  = 7'h1c;
    localparam logic [6:0] OFS_UVR  = 7'h1e;
    localparam logic [6:0] OFS_SCR  = 7'h20;
    localparam logic [6:0] OFS_ISS  = 7'h22;
    localparam logic [6:0] OFS_UVT  = 7'h24;
    localparam logic [6:0] OFS_WDG  = 7'h26;

    // ----------------------------------------------------------------
    // Reset values and accepted code ranges
    // ----------------------------------------------------------------
    localparam logic [7:0] RST_OV   = 8'h3e;
    localparam logic [7:0] RST_UV   = 8'h24;
    localparam logic [3:0] RST_DROP = 4'h0;
    localparam logic [7:0] RST_ILIM = 8'h80;
    localparam logic [7:0] RST_KNEE = 8'hf0;
    localparam logic [1:0] RST_OVR  = 2'h2;
    localparam logic [1:0] RST_UVR  = 2'h0;
    localparam logic [1:0] RST_SCR  = 2'h2;
    localparam logic [3:0] RST_ISS  = 4'h0;
    localparam logic [1:0] RST_UVT  = 2'h3;
    localparam logic [1:0] RST_WDG  = 2'h1;

    localparam logic [7:0] MIN_OV   = 8'h3e;
    localparam logic [7:0] MAX_OV   = 8'hfa;
    localparam logic [7:0] MIN_UV   = 8'h1e;
    localparam logic [7:0] MAX_UV   = 8'hf0;
    localparam logic [3:0] MAX_DROP = 4'hc;
    localparam logic [7:0] MIN_ILIM = 8'h19;
    localparam logic [7:0] MAX_ILIM = 8'h80;
    localparam logic [7:0] MIN_KNEE = 8'h35;
    localparam logic [7:0] MAX_KNEE = 8'hf0;

    // ----------------------------------------------------------------
    // Field codes and bit positions
    // ----------------------------------------------------------------
    localparam logic [1:0] RESP_BAD = 2'h3;
    localparam logic [1:0] SC_NONE  = 2'h0;
    localparam logic [1:0] SC_AR    = 2'h2;
    localparam logic [1:0] WDG_OFF  = 2'h0;
    localparam logic [1:0] WDG_1S   = 2'h2;
    localparam int         HI_PAR   = 15;
    localparam int         CODE_MSB = 8;
    localparam int         LO_PAR   = 7;

    // ----------------------------------------------------------------
    // Watchdog timing
    // ----------------------------------------------------------------
    localparam int          CLK_MHZ     = 250;
    localparam int          WDG_BASE_MS = 500;
    localparam logic [31:0] WDG_BASE_CYC = 32'(WDG_BASE_MS * 1000 * CLK_MHZ);

    typedef struct packed {
        logic        wr;
        logic        rd;
        logic [7:0]  addr;
        logic [15:0] wdata;
    } spcr_req_t;

    typedef struct packed {
        logic [7:0] ov;
        logic [7:0] uv;
        logic [3:0] drop;
        logic [7:0] ilim;
        logic [7:0] knee;
        logic [1:0] ovr;
        logic [1:0] uvr;
        logic [1:0] scr;
        logic [3:0] iss;
        logic [1:0] uvt;
        logic [1:0] wdg;
    } spcr_cfg_t;
endpackage

/* sim/spcr_host.sv */
// Purpose: Host model that issues register requests to the bank
// Assumes: One request at a time, launched just after a rising edge
// Notes:   Each request queues the answer the bench expects
`timescale 1ns/100ps
module spcr_host (
    input  wire logic           i_clk,
    output spcr_pkg::spcr_req_t o_req
);
    logic [16:0] exp_q[$];

    initial o_req = '0;

    function automatic logic [7:0] par_addr(input logic [6:0] b);
        return {~^b, b};
    endfunction

    function automatic logic [15:0] par_word(input logic [7:0] c);
        return {~c[7], 6'h00, c[7], ~^c[6:0], c[6:0]};
    endfunction

    // Idle address and data are inverted, which keeps their parity; wr and rd low keep them unused
    task automatic send(input logic wr, input logic [7:0] a, input logic [15:0] d,
                        input logic e, input logic [15:0] rd_exp);
        @(posedge i_clk);
        o_req <= '{wr: wr, rd: ~wr, addr: a, wdata: d};
        exp_q.push_back({e, rd_exp});
        @(posedge i_clk);
        o_req <= '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: ~d};
    endtask
endmodule

/* sim/supply_protection_command_regs_bench.sv */
// Purpose: Self-checking bench of the supply protection command registers
// Assumes: Watchdog base period shortened to 8 cycles
// Notes:   A monitor compares every acknowledge with the oldest queued note
`timescale 1ns/100ps
module supply_protection_command_regs_bench;
    logic                mclk       = 1'b0;
    logic                arst_n     = 1'b0;
    logic                ce         = 1'b1;
    spcr_pkg::spcr_req_t req;
    spcr_pkg::spcr_cfg_t cfg;
    logic [15:0]         rdata;
    logic                ack;
    logic                err;
    logic                trip;
    logic [16:0]         mon_exp;
    logic [7:0]          cur [11];
    int                  n_mismatch = 0;
    int                  n_checks   = 0;
    int                  n_trip     = 0;
    int                  kr;
    int                  top [11]   = '{251, 241, 13, 129, 241, 3, 3, 3, 15, 3, 3};

    always #2 mclk = ~mclk;

    spcr_host spcr_host_i (.i_clk(mclk), .o_req(req));
    spcr_regs #(.WDG_BASE_CYCLES(32'h8)) spcr_regs_i (.I_MCLK(mclk), .I_ARST_N(arst_n),
        .I_CE(ce), .I_REQ(req), .O_RDATA(rdata), .O_ACK(ack), .O_ERR(err), .O_CFG(cfg),
        .O_WDOG_TRIP(trip));

    task automatic check(input logic [63:0] seen, input logic [63:0] exp);
        n_checks++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("mismatch t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic close_out();
        if (n_mismatch == 0 && n_checks > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask

    function automatic logic [15:0] enc(input int k, input logic [7:0] v);
        return (k == 2 || k > 4) ? {8'h00, v} : spcr_host_i.par_word(v);
    endfunction

    function automatic logic ok(input int k, input logic [7:0] v);
        case (k)
            0: return v >= 8'h3e && v <= 8'hfa;
            1: return v >= 8'h1e && v <= 8'hf0;
            2: return v <= 8'h0c;
            3: return v >= 8'h19 && v <= 8'h80;
            4: return v >= 8'h35 && v <= 8'hf0;
            5, 6: return v != 8'h03;
            7: return v == 8'h00 || v == 8'h02;
            8: return v[1:0] != 2'h3;
            default: return 1'b1;
        endcase
    endfunction

    task automatic rd(input int k);
        spcr_host_i.send(1'b0, spcr_host_i.par_addr(7'(18 + 2 * k)), 16'h0000, 1'b0,
                         enc(k, cur[k]));
        check({14'h0, cfg}, {14'h0, cur[0], cur[1], cur[2][3:0], cur[3], cur[4],
               cur[5][1:0], cur[6][1:0], cur[7][1:0], cur[8][3:0], cur[9][1:0], cur[10][1:0]});
    endtask

    task automatic wrr(input int k, input logic [7:0] v);
        spcr_host_i.send(1'b1, spcr_host_i.par_addr(7'(18 + 2 * k)), enc(k, v), ~ok(k, v),
                         16'h0000);
        if (ok(k, v)) cur[k] = v;
        rd(k);
    endtask

    always @(posedge mclk) begin
        if (trip === 1'b1) n_trip++;
        if (ack === 1'b1) begin
            mon_exp = spcr_host_i.exp_q.size() != 0 ? spcr_host_i.exp_q.pop_front() : '1;
            check({63'h0, err}, {63'h0, mon_exp[16]});
            check({48'h0, rdata}, {48'h0, mon_exp[15:0]});
        end
    end

    initial begin
        #200000;
        n_mismatch++;
        close_out();
    end

    initial begin
        cur = '{8'h3e, 8'h24, 8'h00, 8'h80, 8'hf0, 8'h02, 8'h00, 8'h02, 8'h00, 8'h03, 8'h01};
        void'($urandom(32'h6397));
        repeat (5) @(posedge mclk);
        arst_n <= 1'b1;
        for (int k = 0; k < 11; k++) rd(k);
        for (int k = 0; k < 11; k++)
            for (int v = 0; v <= top[k]; v++) wrr(k, 8'(v));
        repeat (40) begin
            kr = $urandom_range(10, 0);
            wrr(kr, 8'($urandom_range(top[kr], 0)));
        end
        spcr_host_i.send(1'b1, 8'h12, enc(0, 8'h64), 1'b1, 16'h0000);
        spcr_host_i.send(1'b1, 8'h92, enc(0, 8'h64) ^ 16'h8000, 1'b1, 16'h0000);
        spcr_host_i.send(1'b1, 8'h92, enc(0, 8'h64) ^ 16'h0080, 1'b1, 16'h0000);
        spcr_host_i.send(1'b0, 8'hb0, 16'h0000, 1'b1, 16'h0000);
        @(posedge mclk) ce <= 1'b0;
        spcr_host_i.send(1'b1, spcr_host_i.par_addr(7'h12),
                         enc(0, (cur[0] == 8'h50) ? 8'h60 : 8'h50), 1'b0, 16'h0000);
        void'(spcr_host_i.exp_q.pop_back());
        ce <= 1'b1;
        rd(0);
        wrr(10, 8'h02);
        n_trip = 0;
        repeat (40) @(posedge mclk);
        check(64'(n_trip), 64'h2);
        wrr(10, 8'h00);
        n_trip = 0;
        repeat (40) @(posedge mclk);
        check(64'(n_trip), 64'h0);
        check(64'(spcr_host_i.exp_q.size()), 64'h0);
        close_out();
    end
endmodule
